// ### hw/sxe_pkg.sv
// Operation
// - Control code 1010 selects main array
// - Control code 1011 selects security space
// - Chip-select bits must match fixed setting
// - Last control bit one means read
// - Matching control byte acked on ninth clock
// - Two address bytes, only A0-A12 used
// - Address pointer loaded when low address byte ends, as its ack starts
// - STOP commits write; no STOP discards
// - No control-byte ack while write runs
// - Address wraps inside 32-byte page
// - One byte costs a full word time
// - Up to 32 bytes per page write
// - Page buffer wraps past 32 bytes
// - Bytes stored from supplied address upward
// - Buffered words programmed one after another
// - Only protect bits 3 and 2 exist
// - Protect codes: none, quarter, half, all
// - Protect register at security address 0401h
// - Protect write needs 04h, 01h, data, STOP
// - START and STOP from data edges
// - Bytes eight bits, MSB first, plus ack
package sxe_pkg;
    localparam logic [3:0]  CODE_ARRAY   = 4'hA;     // Main array space
    localparam logic [3:0]  CODE_SEC     = 4'hB;     // Security space
    localparam logic [15:0] WP_ADDR      = 16'h0401; // Protect register
    localparam int          ADDR_W       = 13;       // Used address bits
    localparam int          PAGE_BYTES   = 32;       // Page and buffer size
    localparam int          PG_W         = 5;        // Offset bits in page
    localparam int          WORD_LSB     = 2;        // 4-byte program word
    localparam int          BP_LO        = 2;        // Protect low bit
    localparam int          BP_HI        = 3;        // Protect high bit
    localparam logic [1:0]  BP_RESET     = 2'h0;     // Unprotected
    localparam logic [ADDR_W-1:0] BP_QTR_BASE  = 13'h1800;
    localparam logic [ADDR_W-1:0] BP_HALF_BASE = 13'h1000;
    localparam logic [3:0]  BYTE_BITS    = 4'h8;     // Bits per byte
    localparam int          FIFO_DEPTH   = 16;       // Write queue bytes
    // Program time of one word; plain default, tune per process
    localparam int          CLK_NS        = 10;
    localparam int          WORD_WRITE_NS = 10000;
    localparam int          WORD_CYC = (WORD_WRITE_NS + CLK_NS - 1) / CLK_NS;
    localparam int          TIMER_W  = $clog2(WORD_CYC + 1);

    // Bus phases, one-hot
    typedef enum logic [5:0] {
        PH_IDLE = 6'h01,
        PH_CTRL = 6'h02,
        PH_ADRH = 6'h04,
        PH_ADRL = 6'h08,
        PH_DATA = 6'h10,
        PH_SKIP = 6'h20
    } sxe_phase_t;

    // One byte bound for the array
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } sxe_wr_t;
    localparam int WR_W = $bits(sxe_wr_t);

    // Address plus offset, kept inside the page
    function automatic logic [ADDR_W-1:0] page_add(
        input logic [ADDR_W-1:0] a,
        input logic [5:0]        n
    );
        page_add = {a[ADDR_W-1:PG_W], PG_W'(a[PG_W-1:0] + n[PG_W-1:0])};
    endfunction : page_add

    // Protected region test
    function automatic logic is_prot(
        input logic [1:0]        bp,
        input logic [ADDR_W-1:0] a
    );
        unique case (bp)
            2'h0:    is_prot = 1'b0;
            2'h1:    is_prot = a >= BP_QTR_BASE;
            2'h2:    is_prot = a >= BP_HALF_BASE;
            default: is_prot = 1'b1;
        endcase
    endfunction : is_prot
endpackage : sxe_pkg

// ### hw/sxe_fifo.sv
`timescale 1ns/100ps
module sxe_fifo import sxe_pkg::*; #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);

    // Pointers carry one wrap bit
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } sxe_fifo_st_t;

    sxe_fifo_st_t s_r, s_nxt;
    logic [W-1:0] mem [D];   // Storage, no reset needed
    logic         push;
    logic         pop;

    assign out_valid = s_r.wp != s_r.rp;
    assign in_ready  = !((s_r.wp[AW] != s_r.rp[AW]) &&
                         (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]));
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[s_r.rp[AW-1:0]];

    // Pointer update
    always_comb begin
        s_nxt    = s_r;
        s_nxt.wp = s_r.wp + {{AW{1'b0}}, push};
        s_nxt.rp = s_r.rp + {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Storage write
    always_ff @(posedge clock) begin
        if (push) begin
            mem[s_r.wp[AW-1:0]] <= in_data;
        end
    end
endmodule : sxe_fifo

// ### hw/sxe_array.sv
`timescale 1ns/100ps
module sxe_array import sxe_pkg::*; (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire sxe_wr_t           ent,
    input  wire logic              ent_valid,
    output logic                   ent_ready,
    input  wire logic [1:0]        bp,
    input  wire logic [ADDR_W-1:0] peek_addr,
    output logic [7:0]             peek_data,
    output logic                   busy
);
    typedef struct packed {
        logic [TIMER_W-1:0]         timer;   // Word program time left
        logic [ADDR_W-WORD_LSB-1:0] word;    // Word being programmed
        logic                       word_ok; // Word still open
        logic [7:0]                 peek;
    } sxe_arr_st_t;

    sxe_arr_st_t s_r, s_nxt;
    logic [7:0]  mem [2**ADDR_W];  // The cell array
    logic        same_word;
    logic        take;

    // Bytes of the open word join it; a new word waits for the timer
    assign same_word = s_r.word_ok &&
                       s_r.word == ent.addr[ADDR_W-1:WORD_LSB];
    assign ent_ready = s_r.timer == '0 || same_word;
    assign take      = ent_valid && ent_ready;
    assign busy      = s_r.timer != '0;
    assign peek_data = s_r.peek;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.peek = mem[peek_addr];
        if (s_r.timer != '0) begin
            s_nxt.timer = s_r.timer - 1'b1;
            // Word closes when its time runs out
            s_nxt.word_ok = s_r.timer != TIMER_W'(1);
        end
        if (take && !same_word) begin
            s_nxt.timer   = TIMER_W'(WORD_CYC);
            s_nxt.word    = ent.addr[ADDR_W-1:WORD_LSB];
            s_nxt.word_ok = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Cell write, skipped in protected region
    always_ff @(posedge clock) begin
        if (take && !is_prot(bp, ent.addr)) begin
            mem[ent.addr] <= ent.data;
        end
    end

    AST_WORD_TIME: assert property (
        @(posedge clock) disable iff (!rst_n)
        (take && !same_word) |=> busy [*8])
        else $error("word time not held");
endmodule : sxe_array

// ### hw/sxe_eeprom.sv
`timescale 1ns/100ps
module sxe_eeprom import sxe_pkg::*; #(
    // Fixed select setting; 000 or 111 by variant
    parameter logic chip_select_bit_two  = 1'b0,
    parameter logic chip_select_bit_one  = 1'b0,
    parameter logic chip_select_bit_zero = 1'b0
) (
    input  wire logic              clock,
    input  wire logic              nrst,
    input  wire logic              scl,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    input  wire logic [ADDR_W-1:0] peek_addr,
    output logic [7:0]             peek_data,
    output logic [ADDR_W-1:0]      addr_pointer,
    output logic [7:0]             block_protect_config,
    output logic                   write_busy
);
    // Whole block state
    typedef struct packed {
        logic                       scl_m;     // Sync first stage
        logic                       scl_s;     // Sync second stage
        logic                       scl_d;     // Previous synced level
        logic                       sda_m;
        logic                       sda_s;
        logic                       sda_d;
        sxe_phase_t                 phase;     // Byte position
        logic [3:0]                 bitcnt;    // Bits in this byte
        logic [7:0]                 shreg;     // Incoming byte
        logic                       ack_slot;  // In ninth clock
        logic                       sda_drive; // Pull data low
        logic                       sec;       // Security space
        logic [15:0]                addr;      // Supplied address
        logic [ADDR_W-1:0]          ptr;       // Address pointer
        logic [5:0]                 nbytes;    // Bytes held, saturates
        logic [PG_W-1:0]            widx;      // Buffer write slot
        logic [PAGE_BYTES-1:0][7:0] pbuf;      // Page buffer
        logic                       commit;    // Draining buffer
        logic [5:0]                 cidx;      // Drain slot
        logic [5:0]                 ccnt;      // Bytes to drain
        logic                       block_protect_high;
        logic                       block_protect_low;
    } sxe_top_st_t;

    logic [1:0]  rst_sync_r;    // Reset release stages
    logic        rst_n;         // Synchronised reset
    sxe_top_st_t s_r, s_nxt;
    logic        rise;          // Clock line rose
    logic        fall;          // Clock line fell
    logic        start_c;       // Start seen
    logic        stop_c;        // Stop seen
    logic        byte_done;     // Eighth bit in, at clock fall
    logic        ctrl_sel;      // Control byte names us
    logic        busy;          // Internal write cycle running
    logic [2:0]  chip_sel;      // Fixed select bits
    logic [1:0]  bp;            // Protect bits as a pair
    sxe_wr_t     fifo_in;       // Next byte to program
    logic        fifo_in_ready;
    logic [WR_W-1:0] fifo_out;
    logic        fifo_out_valid;
    logic        arr_ready;
    logic        arr_busy;

    // Reset goes low at once, releases after two clocks
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    assign chip_sel = {chip_select_bit_two, chip_select_bit_one,
                       chip_select_bit_zero};
    assign bp       = {s_r.block_protect_high, s_r.block_protect_low};

    // Edges seen only on the synced copies
    assign rise    = s_r.scl_s && !s_r.scl_d;
    assign fall    = !s_r.scl_s && s_r.scl_d;
    assign start_c = s_r.scl_s && s_r.scl_d && s_r.sda_d && !s_r.sda_s;
    assign stop_c  = s_r.scl_s && s_r.scl_d && !s_r.sda_d && s_r.sda_s;

    // Byte boundary falls on the eighth clock's falling edge
    assign byte_done = fall && !s_r.ack_slot &&
                       s_r.bitcnt == BYTE_BITS &&
                       s_r.phase != PH_IDLE;

    // Code and select bits both must match
    assign ctrl_sel = (s_r.shreg[7:4] == CODE_ARRAY ||
                       s_r.shreg[7:4] == CODE_SEC) &&
                      s_r.shreg[3:1] == chip_sel;

    // Busy spans buffer drain, queue and the last word's time
    assign busy = s_r.commit || fifo_out_valid || arr_busy;

    // Drain source for the write queue
    assign fifo_in.addr = page_add(s_r.addr[ADDR_W-1:0], s_r.cidx);
    assign fifo_in.data = s_r.pbuf[s_r.cidx[PG_W-1:0]];

    // Next-state logic
    always_comb begin
        s_nxt       = s_r;
        s_nxt.scl_m = scl;
        s_nxt.scl_s = s_r.scl_m;
        s_nxt.scl_d = s_r.scl_s;
        s_nxt.sda_m = sda_in;
        s_nxt.sda_s = s_r.sda_m;
        s_nxt.sda_d = s_r.sda_s;

        // Buffer drain, stalled by the queue
        if (s_r.commit && fifo_in_ready) begin
            s_nxt.cidx = 6'(s_r.cidx + 6'h01);
            if (6'(s_r.cidx + 6'h01) == s_r.ccnt) begin
                s_nxt.commit = 1'b0;
            end
        end

        if (start_c) begin
            // New transfer; uncommitted bytes are dropped
            s_nxt.phase     = PH_CTRL;
            s_nxt.bitcnt    = 4'h0;
            s_nxt.ack_slot  = 1'b0;
            s_nxt.sda_drive = 1'b0;
            s_nxt.nbytes    = 6'h00;
            s_nxt.widx      = '0;
        end else if (stop_c) begin
            // Stop after data commits the write
            if (s_r.phase == PH_DATA && s_r.nbytes != 6'h00 && !busy) begin
                if (!s_r.sec) begin
                    s_nxt.commit = 1'b1;
                    s_nxt.cidx   = 6'h00;
                    s_nxt.ccnt   = s_r.nbytes;
                end else if (s_r.addr == WP_ADDR) begin
                    // Only two bits are kept, the rest read zero
                    s_nxt.block_protect_high = s_r.pbuf[0][BP_HI];
                    s_nxt.block_protect_low  = s_r.pbuf[0][BP_LO];
                end
            end
            s_nxt.phase     = PH_IDLE;
            s_nxt.sda_drive = 1'b0;
            s_nxt.ack_slot  = 1'b0;
        end else if (s_r.phase != PH_IDLE) begin
            // Sample data while the clock is high, MSB first
            if (rise && !s_r.ack_slot) begin
                s_nxt.shreg  = {s_r.shreg[6:0], s_r.sda_s};
                s_nxt.bitcnt = 4'(s_r.bitcnt + 4'h1);
            end
            if (fall && s_r.ack_slot) begin
                // Ninth clock over: free the line
                s_nxt.ack_slot  = 1'b0;
                s_nxt.sda_drive = 1'b0;
                s_nxt.bitcnt    = 4'h0;
            end else if (byte_done) begin
                s_nxt.ack_slot = 1'b1;
                unique case (s_r.phase)
                    PH_CTRL: begin
                        // Silent while programming so polling works
                        if (ctrl_sel && !busy) begin
                            s_nxt.sda_drive = 1'b1;
                            s_nxt.sec = s_r.shreg[4:1] == {CODE_SEC[0],
                                                           chip_sel};
                            // Reads are acked, then ignored
                            s_nxt.phase = s_r.shreg[0] ? PH_SKIP
                                                       : PH_ADRH;
                        end else begin
                            s_nxt.phase = PH_SKIP;
                        end
                    end
                    PH_ADRH: begin
                        s_nxt.addr[15:8] = s_r.shreg;
                        s_nxt.sda_drive  = 1'b1;
                        s_nxt.phase      = PH_ADRL;
                    end
                    PH_ADRL: begin
                        s_nxt.addr[7:0] = s_r.shreg;
                        // Upper address bits are ignored
                        s_nxt.ptr = {s_r.addr[ADDR_W-1:8], s_r.shreg};
                        s_nxt.sda_drive = 1'b1;
                        s_nxt.nbytes    = 6'h00;
                        s_nxt.widx      = '0;
                        s_nxt.phase     = PH_DATA;
                    end
                    PH_DATA: begin
                        // Slot wraps, overwriting the oldest byte
                        s_nxt.pbuf[s_r.widx] = s_r.shreg;
                        s_nxt.widx = PG_W'(s_r.widx + 1'b1);
                        if (s_r.nbytes != 6'(PAGE_BYTES)) begin
                            s_nxt.nbytes = 6'(s_r.nbytes + 6'h01);
                        end
                        s_nxt.ptr = page_add(s_r.ptr, 6'h01);
                        s_nxt.sda_drive = 1'b1;
                    end
                    default: begin
                        // Skipped bytes (foreign, busy or read): clock on without answering
                        s_nxt.sda_drive = 1'b0;
                    end
                endcase
            end
        end
    end

    // State register; bus lines idle high after reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r       <= '0;
            s_r.phase <= PH_IDLE;
            s_r.scl_m <= 1'b1;
            s_r.scl_s <= 1'b1;
            s_r.scl_d <= 1'b1;
            s_r.sda_m <= 1'b1;
            s_r.sda_s <= 1'b1;
            s_r.sda_d <= 1'b1;
            s_r.block_protect_high <= BP_RESET[1];
            s_r.block_protect_low  <= BP_RESET[0];
        end else begin
            s_r <= s_nxt;
        end
    end

    // Write queue between buffer drain and array
    sxe_fifo #(
        .W (WR_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_data   (fifo_in),
        .in_valid  (s_r.commit),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (arr_ready)
    );

    // Cell array with word timing and protection
    sxe_array u_array (
        .clock     (clock),
        .rst_n     (rst_n),
        .ent       (fifo_out),
        .ent_valid (fifo_out_valid),
        .ent_ready (arr_ready),
        .bp        (bp),
        .peek_addr (peek_addr),
        .peek_data (peek_data),
        .busy      (arr_busy)
    );

    // Open drain: only ever pulls low
    assign sda_out      = 1'b0;
    assign sda_oe       = s_r.sda_drive;
    assign addr_pointer = s_r.ptr;
    assign write_busy   = busy;
    assign block_protect_config = {4'h0, s_r.block_protect_high,
                                   s_r.block_protect_low, 2'h0};

    // Bus-side checks; each watches registered state
    AST_CTRL_ACK: assert property (
        @(posedge clock) disable iff (!rst_n)
        (byte_done && !start_c && !stop_c && s_r.phase == PH_CTRL &&
         ctrl_sel && !busy) |=> sda_oe until_with fall)
        else $error("control byte not acked");

    AST_BUSY_NACK: assert property (
        @(posedge clock) disable iff (!rst_n)
        (byte_done && !start_c && !stop_c && s_r.phase == PH_CTRL &&
         busy) |=> !sda_oe)
        else $error("acked while busy");

    AST_CS_MISS: assert property (
        @(posedge clock) disable iff (!rst_n)
        (byte_done && !start_c && !stop_c && s_r.phase == PH_CTRL &&
         s_r.shreg[3:1] != chip_sel) |=> !sda_oe && s_r.phase == PH_SKIP)
        else $error("foreign select acked");

    AST_READ_DIR: assert property (
        @(posedge clock) disable iff (!rst_n)
        (byte_done && !start_c && !stop_c && s_r.phase == PH_CTRL &&
         ctrl_sel && !busy && s_r.shreg[0]) |=> s_r.phase == PH_SKIP)
        else $error("read not taken as read");

    AST_PTR_LOAD: assert property (
        @(posedge clock) disable iff (!rst_n)
        (byte_done && !start_c && !stop_c && s_r.phase == PH_ADRL)
        |=> s_r.ptr[7:0] == $past(s_r.shreg) && s_r.phase == PH_DATA)
        else $error("pointer not loaded");

    AST_PAGE_WRAP: assert property (
        @(posedge clock) disable iff (!rst_n)
        ($past(s_r.phase) == PH_DATA && $changed(s_r.ptr))
        |-> s_r.ptr[ADDR_W-1:PG_W] == $past(s_r.ptr[ADDR_W-1:PG_W]))
        else $error("pointer left page");

    AST_NO_STOP: assert property (
        @(posedge clock) disable iff (!rst_n)
        (start_c && s_r.phase == PH_DATA && !s_r.commit)
        |=> !s_r.commit [*2])
        else $error("write without stop");

    AST_COMMIT: assert property (
        @(posedge clock) disable iff (!rst_n)
        (stop_c && s_r.phase == PH_DATA && s_r.nbytes != 6'h00 &&
         !s_r.sec && !busy) |=> s_r.commit && s_r.cidx == 6'h00 &&
        s_r.ccnt == $past(s_r.nbytes))
        else $error("commit missing");

    AST_BP_STOP: assert property (
        @(posedge clock) disable iff (!rst_n)
        $changed(bp) |-> $past(stop_c) && $past(s_r.sec))
        else $error("protect bits changed without stop");

    AST_SAME_PAGE: assert property (
        @(posedge clock) disable iff (!rst_n)
        s_r.commit |-> fifo_in.addr[ADDR_W-1:PG_W] ==
                       s_r.addr[ADDR_W-1:PG_W])
        else $error("commit crossed page");

    // Ack is let go once the ninth clock falls
    AST_ACK_RELEASE: assert property (
        @(posedge clock) disable iff (!rst_n)
        (fall && s_r.ack_slot && !start_c && !stop_c) |=> !sda_oe)
        else $error("ack held past ninth clock");

    // Reads and foreign bytes never pull the line outside the ack slot
    AST_SKIP_QUIET: assert property (
        @(posedge clock) disable iff (!rst_n)
        (s_r.phase == PH_SKIP && !s_r.ack_slot) |-> !sda_oe)
        else $error("line pulled while ignoring");

    // Free bus after STOP: line left alone
    AST_IDLE_QUIET: assert property (
        @(posedge clock) disable iff (!rst_n)
        s_r.phase == PH_IDLE |-> !sda_oe)
        else $error("line pulled while idle");

    // Drain moves one slot per byte the queue takes
    AST_DRAIN_STEP: assert property (
        @(posedge clock) disable iff (!rst_n)
        (s_r.commit && fifo_in_ready)
        |=> s_r.cidx == 6'($past(s_r.cidx) + 6'h01))
        else $error("drain slot skipped");
endmodule : sxe_eeprom

// ### testbench/sxe_master.sv
`timescale 1ns/100ps
// Bus master model; clock stands still high between frames
module sxe_master (
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda
);
    // Idle bus, both lines high
    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end
    // Data falls while clock high
    task automatic start_c();
        sda_m = 1'b1;
        #40 scl = 1'b1;
        #80 sda_m = 1'b0;
        #80 scl = 1'b0;
        #40;
    endtask : start_c
    // Data rises while clock high
    task automatic stop_c();
        sda_m = 1'b0;
        #40 scl = 1'b1;
        #80 sda_m = 1'b1;
        #80;
    endtask : stop_c
    // Eight bits MSB first, then line released for the ack
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_m = (i > 0) ? b[i-1] : 1'b1;
            #40 scl = 1'b1;
            #40 if (i == 0) ack = !sda;
            #40 scl = 1'b0;
            #40;
        end
    endtask : put_byte
endmodule : sxe_master

// ### testbench/tb.sv
`timescale 1ns/100ps
module tb import sxe_pkg::*;;
    logic              clock, nrst, scl, sda_m, sda, sda_out, sda_oe;
    logic [ADDR_W-1:0] peek_addr, addr_pointer;
    logic [7:0]        peek_data, block_protect_config;
    logic              write_busy, ack;
    logic [7:0]        dq [64];   // Data bytes of one transfer
    logic [7:0]        ctl [6] = '{8'hA0, 8'hC0, 8'hAE, 8'hB0, 8'hA1, 8'h50};
    logic              exp [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [ADDR_W-1:0] a;
    int                fail_count = 0, comparisons = 0;
    // Wired-AND data line with pull-up
    assign sda = sda_oe ? sda_out : sda_m;
    sxe_eeprom i_dut (.clock(clock), .nrst(nrst), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .peek_addr(peek_addr),
        .peek_data(peek_data), .addr_pointer(addr_pointer),
        .block_protect_config(block_protect_config),
        .write_busy(write_busy));
    sxe_master u_master (.scl(scl), .sda_m(sda_m), .sda(sda));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Page-local increment
    function automatic logic [12:0] wrap(input logic [12:0] x, input int n);
        wrap = {x[12:5], x[4:0] + 5'(n)};
    endfunction : wrap
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t: %s", $time, m);
        end
    endtask : chk
    // Control, two address bytes, n data bytes, optional STOP
    task automatic xfer(input logic [7:0] c, input logic [15:0] ad,
                        input int n, input bit st);
        u_master.start_c();
        u_master.put_byte(c, ack);
        chk(ack === 1'b1, "control not acked");
        u_master.put_byte(ad[15:8], ack);
        chk(ack === 1'b1, "high address not acked");
        u_master.put_byte(ad[7:0], ack);
        chk(ack === 1'b1, "low address not acked");
        for (int i = 0; i < n; i++) begin
            u_master.put_byte(dq[i], ack);
            chk(ack === 1'b1, "data not acked");
            chk(c[7:4] != CODE_ARRAY || addr_pointer === wrap(ad[12:0], i + 1),
                "pointer wrong");
        end
        if (st) u_master.stop_c();
    endtask : xfer
    // Control byte alone; returns the ack
    task automatic poll(input logic [7:0] c);
        u_master.start_c();
        u_master.put_byte(c, ack);
        u_master.stop_c();
    endtask : poll
    task automatic wait_idle();
        for (int i = 0; i < 40000 && write_busy !== 1'b0; i++)
            @(negedge clock);
        chk(write_busy === 1'b0, "write cycle stuck");
        if (write_busy !== 1'b0) close_out();
    endtask : wait_idle
    task automatic peek(input logic [12:0] x, input logic [7:0] e);
        peek_addr = x;
        repeat (2) @(negedge clock);
        chk(peek_data === e, "array byte wrong");
    endtask : peek
    // Main sequence
    initial begin
        nrst = 1'b0;
        peek_addr = '0;
        void'($urandom(32'h09c8f9ba));
        repeat (4) @(negedge clock);
        nrst = 1'b1;
        repeat (8) @(negedge clock);
        chk(block_protect_config === 8'h00, "protect reset");
        // Codes, select bits and direction
        foreach (ctl[i]) begin
            poll(ctl[i]);
            chk(ack === exp[i], "control ack wrong");
        end
        // Reserved bits stay zero; no STOP keeps the old value
        dq[0] = 8'($urandom) | 8'hFB;
        xfer(8'hB0, WP_ADDR, 1, 1);
        chk(block_protect_config === {4'h0, dq[0][3:2], 2'h0}, "wp");
        dq[1] = dq[0];
        dq[0] = 8'hF3;
        xfer(8'hB0, WP_ADDR, 1, 0);
        u_master.start_c();
        u_master.stop_c();
        chk(block_protect_config === {4'h0, dq[1][3:2], 2'h0}, "wp");
        xfer(8'hB0, WP_ADDR, 1, 1);
        chk(block_protect_config === 8'h00, "protect not cleared");
        // Byte write at page end, busy polling
        a = {8'($urandom), 5'h1F};
        dq[0] = 8'($urandom);
        xfer(8'hA0, {3'h0, a}, 1, 1);
        chk(write_busy === 1'b1, "no write cycle");
        poll(8'hA0);
        chk(ack === 1'b0, "acked while busy");
        wait_idle();
        poll(8'hA0);
        chk(ack === 1'b1, "no ack after write");
        peek(a, dq[0]);
        // 33 bytes from offset 5: buffer wraps, 9 words programmed
        for (int i = 0; i < 33; i++) dq[i] = 8'($urandom);
        xfer(8'hA0, 16'h1805, 33, 1);
        repeat (7000) @(negedge clock);
        chk(write_busy === 1'b1, "page write too short");
        wait_idle();
        for (int i = 1; i <= 32; i++) peek(wrap(13'h1805, i), dq[i]);
        // Top quarter protected: cell must not change
        a = 13'h1805;
        dq[32] = dq[32];
        dq[0] = 8'h04;
        xfer(8'hB0, WP_ADDR, 1, 1);
        dq[0] = ~dq[32];
        xfer(8'hA0, {3'h0, a}, 1, 1);
        wait_idle();
        peek(a, dq[32]);
        // Just below the top quarter stays writable
        dq[0] = 8'($urandom);
        xfer(8'hA0, 16'h17FF, 1, 1);
        wait_idle();
        peek(13'h17FF, dq[0]);
        // Data without STOP is discarded
        xfer(8'hA0, 16'h0100, 1, 0);
        u_master.start_c();
        u_master.stop_c();
        chk(write_busy === 1'b0, "write without STOP");
        close_out();
    end
endmodule : tb
